//--- include/pwm_pkg.sv
// constants, field positions, reset values and types of the three-phase pwm block
// assumes a 16-bit register port with word-aligned byte addresses
package pwm_pkg;

  localparam int DATA_W     = 16;
  localparam int ADDR_W     = 8;
  localparam int NUM_PHASES = 3;
  localparam int NUM_EVENTS = 3;

  // register byte addresses
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DUTY_A = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_DUTY_B = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_DUTY_C = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_DEAD   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_OUTEN  = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_GATE   = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_CLEAR  = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_IRQEN  = 8'h28;

  // control and output-enable register fields
  localparam int CTRL_EN       = 0;
  localparam int CTRL_DOUBLE   = 1;
  localparam int CTRL_EXT_SYNC = 2;
  localparam int CTRL_ACT_LOW  = 3;
  localparam int CTRL_SR_LSB   = 4;
  localparam int CTRL_GATE_HI  = 6;
  localparam int CTRL_GATE_LO  = 7;
  localparam int OUTEN_XOVER   = 8;

  // status bits
  localparam int ST_TRIP     = 0;
  localparam int ST_PERIOD   = 1;
  localparam int ST_EXT_SYNC = 2;
  localparam int ST_PIN_LVL  = 3;

  // reset values
  localparam logic [DATA_W-1:0] CTRL_RST    = 16'h0000;
  localparam logic [DATA_W-1:0] PERIOD_RST  = 16'h0100;
  localparam logic [DATA_W-1:0] DUTY_RST    = 16'h0000;
  localparam logic [DATA_W-1:0] DEAD_RST    = 16'h0004;
  localparam logic [DATA_W-1:0] OUTEN_RST   = 16'h003F;
  localparam logic [DATA_W-1:0] GATE_RST    = 16'h0004;
  localparam logic [DATA_W-1:0] RD_UNMAPPED = 16'h0000;
  localparam logic [1:0]        PIN_RST     = 2'h1;

  typedef enum logic {CNT_UP, CNT_DOWN} cnt_dir_t;
  typedef enum logic [1:0] {SR_OFF, SR_SAME, SR_LO_ON, SR_HI_ON} sr_mode_t;

endpackage

//--- include/phase_if.sv
// one phase: compare result toward the dead-time stage, gate requests back
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface phase_if #(parameter int DW = 8);
  logic          rawOn;
  logic [DW-1:0] deadCycles;
  logic          hiOn;
  logic          loOn;
  modport gen (output rawOn, output deadCycles, input hiOn, input loOn);
  modport dt  (input rawOn, input deadCycles, output hiOn, output loOn);
endinterface

//--- logic/sync_two_ff.sv
// two-flop synchroniser for pin inputs
// assumes inputs are asynchronous levels
`timescale 1ns/10ps
module sync_two_ff #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,  // system clock
  input  wire logic         nrst, // sync reset, active low
  input  wire logic [W-1:0] din,  // asynchronous levels
  output logic      [W-1:0] dout  // synchronised levels
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } state_t;

  state_t st_q;
  state_t st_d;

  always_comb begin
    st_d        = st_q;
    st_d.meta   = din;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= {RST_VAL, RST_VAL};
    end else begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.stable;
endmodule

//--- logic/dead_time_phase.sv
// dead-time insertion for one complementary output pair
// assumes deadCycles is stable while a gap is running
`timescale 1ns/10ps
module dead_time_phase #(
  parameter int DW = 8
) (
  input wire logic clk,  // system clock
  input wire logic nrst, // sync reset, active low
  phase_if.dt      ph    // compare in, gate requests out
);
  typedef struct packed {
    logic          cur;
    logic [DW-1:0] cnt;
    logic          hi;
    logic          lo;
  } state_t;

  state_t st_q;
  state_t st_d;

  always_comb begin
    st_d = st_q;
    if (ph.rawOn != st_q.cur) begin
      st_d.cur = ph.rawOn;
      st_d.cnt = ph.deadCycles;
      st_d.hi  = 1'b0;
      st_d.lo  = 1'b0;
    end else if (st_q.cnt != '0) begin
      st_d.cnt = st_q.cnt - 1'b1;
    end else begin
      st_d.hi = st_q.cur;
      st_d.lo = ~st_q.cur;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign ph.hiOn = st_q.hi;
  assign ph.loOn = st_q.lo;

  sequence s_gap;
    !ph.hiOn && !ph.loOn;
  endsequence

  a_dead_excl: assert property (
    @(posedge clk) disable iff (!nrst) !(ph.hiOn && ph.loOn))
    else $error("both sides of a phase on");

  a_dead_gap: assert property (
    @(posedge clk) disable iff (!nrst) $changed(ph.rawOn) |=> s_gap)
    else $error("no dead gap after switch");
endmodule

//--- logic/three_phase_center_pwm.sv
// three-phase center-based pwm generator with dead time, sync and trip
// assumes a one-cycle strobe register port on clk; trip and sync pins asynchronous
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Function
// - up/down 16-bit counter, centered pulses
// - software period register sets frequency
// - six drives: high/low for A,B,C
// - software selects active-high or active-low outputs
// - single update: load duty once per period
// - double update: reload duty at midpoint
// - internal sync pulse driven on pin
// - external sync pulses realign the counter
// - trip low forces outputs off asynchronously
// - signed duty saturates to full on/off
// - programmable dead time, one setting shared by all three phases
// - crossover and per-output enables
// - selectable switched reluctance output patterns
// - chopping clock gates outputs
module three_phase_center_pwm #(
  parameter int DEAD_W = 8
) (
  input  wire logic        clk,                   // system clock, 200 MHz
  input  wire logic        nrst,                  // sync reset, active low
  input  wire logic [7:0]  addr,                  // register byte address
  input  wire logic [15:0] wrData,                // write data
  input  wire logic        wrEn,                  // write strobe
  input  wire logic        rdEn,                  // read strobe
  output logic      [15:0] rdData,                // read data, cycle after strobe
  output logic             irq,                   // level interrupt
  output logic             phase_a_high_drive,    // phase A high side
  output logic             phase_b_high_drive,    // phase B high side
  output logic             phase_c_high_drive,    // phase C high side
  output logic             phase_a_low_drive,     // phase A low side
  output logic             phase_b_low_drive,     // phase B low side
  output logic             phase_c_low_drive,     // phase C low side
  input  wire logic        period_sync_pin_in,    // sync pin level
  output logic             period_sync_pin_out,   // sync pin drive value
  output logic             period_sync_pin_oe,    // sync pin drive enable
  input  wire logic        shutdown_trip_input_n  // trip pin, active low
);
  localparam int DW = pwm_pkg::DATA_W;
  localparam int NP = pwm_pkg::NUM_PHASES;

  if (DEAD_W < 1 || DEAD_W > DW) begin : g_chk
    $error("DEAD_W must lie between 1 and the data width");
  end

  typedef struct packed {
    logic [DW-1:0]                ctrl;
    logic [DW-1:0]                period;
    logic [NP-1:0][DW-1:0]        duty;
    logic [NP-1:0][DW-1:0]        dutyAct;
    logic [DW-1:0]                dead;
    logic [DW-1:0]                outEn;
    logic [DW-1:0]                gateDiv;
    logic [DW-1:0]                gateCnt;
    logic [DW-1:0]                cnt;
    pwm_pkg::cnt_dir_t            dir;
    logic [pwm_pkg::NUM_EVENTS-1:0] status;
    logic [pwm_pkg::NUM_EVENTS-1:0] irqEn;
    logic                         chop;
    logic                         syncPrev;
    logic                         syncOut;
    logic                         tripLat;
    logic                         irq;
    logic [DW-1:0]                rdData;
    logic [2*NP-1:0]              drive;
  } state_t;

  localparam state_t ST_RST = '{
    ctrl:     pwm_pkg::CTRL_RST,
    period:   pwm_pkg::PERIOD_RST,
    duty:     {NP{pwm_pkg::DUTY_RST}},
    dutyAct:  {NP{pwm_pkg::DUTY_RST}},
    dead:     pwm_pkg::DEAD_RST,
    outEn:    pwm_pkg::OUTEN_RST,
    gateDiv:  pwm_pkg::GATE_RST,
    gateCnt:  '0,
    cnt:      '0,
    dir:      pwm_pkg::CNT_UP,
    status:   '0,
    irqEn:    '0,
    chop:     1'b0,
    syncPrev: 1'b0,
    syncOut:  1'b0,
    tripLat:  1'b0,
    irq:      1'b0,
    rdData:   pwm_pkg::RD_UNMAPPED,
    drive:    '0
  };

  state_t                          st_q;
  state_t                          st_d;
  logic [1:0]                      pinSync;
  logic                            tripOk;
  logic                            syncLvl;
  logic                            syncRise;
  logic                            en;
  logic                            extMode;
  logic                            extRestart;
  logic                            start;
  logic                            mid;
  logic [pwm_pkg::NUM_EVENTS-1:0]  evt;
  logic [pwm_pkg::NUM_EVENTS-1:0]  clr;
  logic [2*NP-1:0]                 outQ;
  wire  [2*NP-1:0]                 drvNext;

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: bit 0 trip, bit 1 sync
  sync_two_ff #(.W(2), .RST_VAL(pwm_pkg::PIN_RST)) u_pin_sync (
    .clk  (clk),
    .nrst (nrst),
    .din  ({period_sync_pin_in, shutdown_trip_input_n}),
    .dout (pinSync)
  );

  assign tripOk     = pinSync[0];
  assign syncLvl    = pinSync[1];
  assign syncRise   = syncLvl & ~st_q.syncPrev;
  assign en         = st_q.ctrl[pwm_pkg::CTRL_EN];
  assign extMode    = st_q.ctrl[pwm_pkg::CTRL_EXT_SYNC];
  assign extRestart = en & extMode & syncRise;

  ////////////////////////////////////////////////////////////////////////////////
  // per-phase compare, dead time and output shaping
  for (genvar i = 0; i < NP; i++) begin : g_phase
    phase_if #(.DW(DEAD_W)) ph ();
    logic hiX;
    logic loX;
    logic hiS;
    logic loS;

    assign ph.rawOn = en & ($signed({2'b00, st_q.cnt}) >
                      ($signed({2'b00, st_q.period}) -
                       $signed({{2{st_q.dutyAct[i][DW-1]}}, st_q.dutyAct[i]})));
    assign ph.deadCycles = st_q.dead[DEAD_W-1:0];

    dead_time_phase #(.DW(DEAD_W)) u_dead (
      .clk  (clk),
      .nrst (nrst),
      .ph   (ph.dt)
    );

    assign hiX = st_q.outEn[pwm_pkg::OUTEN_XOVER + i] ? ph.loOn : ph.hiOn;
    assign loX = st_q.outEn[pwm_pkg::OUTEN_XOVER + i] ? ph.hiOn : ph.loOn;

    always_comb begin
      hiS = hiX;
      loS = loX;
      case (pwm_pkg::sr_mode_t'(st_q.ctrl[pwm_pkg::CTRL_SR_LSB +: 2]))
        pwm_pkg::SR_OFF: begin
          hiS = hiX;
          loS = loX;
        end
        pwm_pkg::SR_SAME: begin
          hiS = hiX;
          loS = hiX;
        end
        pwm_pkg::SR_LO_ON: begin
          hiS = hiX;
          loS = 1'b1;
        end
        pwm_pkg::SR_HI_ON: begin
          hiS = 1'b1;
          loS = hiX;
        end
        default: begin
          hiS = 1'b0;
          loS = 1'b0;
        end
      endcase
    end

    assign drvNext[i]      = hiS & (~st_q.ctrl[pwm_pkg::CTRL_GATE_HI] | st_q.chop) &
                             st_q.outEn[i];
    assign drvNext[i + NP] = loS & (~st_q.ctrl[pwm_pkg::CTRL_GATE_LO] | st_q.chop) &
                             st_q.outEn[i + NP];

    a_full_off: assert property (
      @(posedge clk) disable iff (!nrst)
      $signed(st_q.dutyAct[i]) <= 0 |-> !ph.rawOn)
      else $error("non-positive duty not fully off");

    a_full_on: assert property (
      @(posedge clk) disable iff (!nrst)
      en && ($signed({st_q.dutyAct[i][DW-1], st_q.dutyAct[i]}) >
             $signed({1'b0, st_q.period})) |-> ph.rawOn)
      else $error("duty above period not fully on");

    a_out_enable: assert property (
      @(posedge clk) disable iff (!nrst)
      !st_q.outEn[i] |=> !st_q.drive[i])
      else $error("disabled output driven");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register port, counter, events
  always_comb begin
    st_d         = st_q;
    st_d.syncOut = 1'b0;
    st_d.rdData  = pwm_pkg::RD_UNMAPPED;
    st_d.syncPrev = syncLvl;
    evt          = '0;
    start        = 1'b0;
    mid          = 1'b0;
    clr          = '0;

    if (wrEn) begin
      if (addr == pwm_pkg::OFS_CTRL) begin
        st_d.ctrl = wrData;
      end else if (addr == pwm_pkg::OFS_PERIOD) begin
        st_d.period = wrData;
      end else if (addr == pwm_pkg::OFS_DUTY_A) begin
        st_d.duty[0] = wrData;
      end else if (addr == pwm_pkg::OFS_DUTY_B) begin
        st_d.duty[1] = wrData;
      end else if (addr == pwm_pkg::OFS_DUTY_C) begin
        st_d.duty[2] = wrData;
      end else if (addr == pwm_pkg::OFS_DEAD) begin
        st_d.dead = wrData;
      end else if (addr == pwm_pkg::OFS_OUTEN) begin
        st_d.outEn = wrData;
      end else if (addr == pwm_pkg::OFS_GATE) begin
        st_d.gateDiv = wrData;
      end else if (addr == pwm_pkg::OFS_CLEAR) begin
        clr = wrData[pwm_pkg::NUM_EVENTS-1:0];
      end else if (addr == pwm_pkg::OFS_IRQEN) begin
        st_d.irqEn = wrData[pwm_pkg::NUM_EVENTS-1:0];
      end
    end

    if (rdEn) begin
      if (addr == pwm_pkg::OFS_CTRL) begin
        st_d.rdData = st_q.ctrl;
      end else if (addr == pwm_pkg::OFS_PERIOD) begin
        st_d.rdData = st_q.period;
      end else if (addr == pwm_pkg::OFS_DUTY_A) begin
        st_d.rdData = st_q.duty[0];
      end else if (addr == pwm_pkg::OFS_DUTY_B) begin
        st_d.rdData = st_q.duty[1];
      end else if (addr == pwm_pkg::OFS_DUTY_C) begin
        st_d.rdData = st_q.duty[2];
      end else if (addr == pwm_pkg::OFS_DEAD) begin
        st_d.rdData = st_q.dead;
      end else if (addr == pwm_pkg::OFS_OUTEN) begin
        st_d.rdData = st_q.outEn;
      end else if (addr == pwm_pkg::OFS_GATE) begin
        st_d.rdData = st_q.gateDiv;
      end else if (addr == pwm_pkg::OFS_STATUS) begin
        st_d.rdData = {{(DW-pwm_pkg::ST_PIN_LVL-1){1'b0}}, tripOk, st_q.status};
      end else if (addr == pwm_pkg::OFS_IRQEN) begin
        st_d.rdData = {{(DW-pwm_pkg::NUM_EVENTS){1'b0}}, st_q.irqEn};
      end
    end

    if (!en) begin
      st_d.cnt = '0;
      st_d.dir = pwm_pkg::CNT_UP;
    end else if (extRestart) begin
      st_d.cnt = '0;
      st_d.dir = pwm_pkg::CNT_UP;
      start    = 1'b1;
    end else begin
      case (st_q.dir)
        pwm_pkg::CNT_UP: begin
          if (st_q.cnt >= st_q.period) begin
            st_d.dir = pwm_pkg::CNT_DOWN;
            st_d.cnt = (st_q.cnt == '0) ? '0 : st_q.cnt - 1'b1;
            mid      = 1'b1;
          end else begin
            st_d.cnt = st_q.cnt + 1'b1;
          end
        end
        pwm_pkg::CNT_DOWN: begin
          if (st_q.cnt <= DW'(1)) begin
            st_d.cnt = '0;
            st_d.dir = pwm_pkg::CNT_UP;
            start    = 1'b1;
          end else begin
            st_d.cnt = st_q.cnt - 1'b1;
          end
        end
        default: begin
          st_d.cnt = '0;
          st_d.dir = pwm_pkg::CNT_UP;
        end
      endcase
    end
    evt[pwm_pkg::ST_EXT_SYNC] = extMode & syncRise;

    if (start) begin
      st_d.dutyAct            = st_q.duty;
      evt[pwm_pkg::ST_PERIOD] = 1'b1;
      st_d.syncOut            = ~extMode;
    end
    if (mid && st_q.ctrl[pwm_pkg::CTRL_DOUBLE]) begin
      st_d.dutyAct = st_q.duty;
    end

    if (st_q.gateCnt >= st_q.gateDiv) begin
      st_d.gateCnt = '0;
      st_d.chop    = ~st_q.chop;
    end else begin
      st_d.gateCnt = st_q.gateCnt + 1'b1;
    end

    if (!tripOk) begin
      st_d.tripLat          = 1'b1;
      evt[pwm_pkg::ST_TRIP] = 1'b1;
    end else if (clr[pwm_pkg::ST_TRIP]) begin
      st_d.tripLat = 1'b0;
    end

    st_d.status = (st_q.status & ~clr) | evt;
    st_d.irq    = |(st_d.status & st_d.irqEn);
    st_d.drive  = (en && tripOk && !st_q.tripLat) ? drvNext : '0;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // output stage
  // asynchronous trip clear
  always_ff @(posedge clk or negedge shutdown_trip_input_n) begin
    if (!shutdown_trip_input_n) begin
      outQ <= '0;
    end else if (!nrst) begin
      outQ <= '0;
    end else begin
      outQ <= st_q.drive;
    end
  end

  assign phase_a_high_drive  = outQ[0] ^ st_q.ctrl[pwm_pkg::CTRL_ACT_LOW];
  assign phase_b_high_drive  = outQ[1] ^ st_q.ctrl[pwm_pkg::CTRL_ACT_LOW];
  assign phase_c_high_drive  = outQ[2] ^ st_q.ctrl[pwm_pkg::CTRL_ACT_LOW];
  assign phase_a_low_drive   = outQ[3] ^ st_q.ctrl[pwm_pkg::CTRL_ACT_LOW];
  assign phase_b_low_drive   = outQ[4] ^ st_q.ctrl[pwm_pkg::CTRL_ACT_LOW];
  assign phase_c_low_drive   = outQ[5] ^ st_q.ctrl[pwm_pkg::CTRL_ACT_LOW];
  assign period_sync_pin_out = st_q.syncOut;
  assign period_sync_pin_oe  = ~extMode;
  assign rdData              = st_q.rdData;
  assign irq                 = st_q.irq;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_sync_one;
    st_q.syncOut ##1 !st_q.syncOut;
  endsequence

  a_count_turn: assert property (
    @(posedge clk) disable iff (!nrst)
    en && !extRestart && st_q.dir == pwm_pkg::CNT_UP && st_q.cnt >= st_q.period
    |=> st_q.dir == pwm_pkg::CNT_DOWN)
    else $error("counter did not turn at top");

  a_period_write: assert property (
    @(posedge clk) disable iff (!nrst)
    wrEn && addr == pwm_pkg::OFS_PERIOD |=> st_q.period == $past(wrData))
    else $error("period write lost");

  a_single_hold: assert property (
    @(posedge clk) disable iff (!nrst)
    mid && !st_q.ctrl[pwm_pkg::CTRL_DOUBLE] |=> $stable(st_q.dutyAct))
    else $error("duty reloaded at midpoint in single mode");

  a_double_load: assert property (
    @(posedge clk) disable iff (!nrst)
    mid && st_q.ctrl[pwm_pkg::CTRL_DOUBLE] |=> st_q.dutyAct == $past(st_q.duty))
    else $error("duty not reloaded at midpoint");

  a_sync_pulse: assert property (
    @(posedge clk) disable iff (!nrst)
    start && !extMode |=> s_sync_one)
    else $error("sync pulse not one cycle at period start");

  a_ext_align: assert property (
    @(posedge clk) disable iff (!nrst)
    extRestart |=> st_q.cnt == '0 && st_q.dir == pwm_pkg::CNT_UP)
    else $error("external sync did not realign counter");

  a_trip_off: assert property (
    @(posedge clk) disable iff (!nrst)
    !shutdown_trip_input_n |-> outQ == '0)
    else $error("outputs on during trip");

  a_trip_hold: assert property (
    @(posedge clk) disable iff (!nrst)
    st_q.tripLat && !(clr[pwm_pkg::ST_TRIP] && tripOk)
    |=> st_q.tripLat && st_q.drive == '0)
    else $error("trip latch released without clear");
endmodule

//--- sim/pwm_far_side.sv
// far side of the pwm block: external sync source sharing the pin, trip switch
// assumes the block's drive enable says who owns the sync pin
`timescale 1ns/10ps
module pwm_far_side (
  input  wire logic clk,     // system clock
  input  wire logic pinOe,   // block drives sync pin
  input  wire logic pinOut,  // block sync value
  output logic      pinLvl,  // resolved sync pin
  output logic      tripLvlN // trip pin, active low
);
  logic extLvl;

  initial begin
    extLvl = 1'b0;
    tripLvlN = 1'b1;
  end

  assign pinLvl = pinOe ? pinOut : extLvl;

  task automatic pulse();
    @(posedge clk);
    extLvl <= 1'b1;
    repeat (3) @(posedge clk);
    extLvl <= 1'b0;
  endtask

  task automatic setTrip(input logic lvl);
    tripLvlN <= lvl;
  endtask
endmodule

//--- sim/tb_three_phase_center_pwm.sv
// self-checking bench of the three-phase pwm block
// assumes pwm_pkg and pwm_far_side are compiled first
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module tb_three_phase_center_pwm;
  logic        clk;
  logic        nrst;
  logic        wrEn;
  logic        rdEn;
  logic [7:0]  addr;
  logic [15:0] wrData;
  logic [15:0] rdData;
  logic [15:0] rv;
  logic        irq;
  logic        syncOut;
  logic        syncOe;
  logic        syncIn;
  logic        tripN;
  logic [5:0]  drv;  // {cl,bl,al,ch,bh,ah}
  logic [31:0] seed;
  logic [15:0] dutyA;
  logic [15:0] dutyB;
  int          failures;
  int          checked;
  int          pulses;

  three_phase_center_pwm dut_u (
    .clk(clk), .nrst(nrst), .addr(addr), .wrData(wrData), .wrEn(wrEn),
    .rdEn(rdEn), .rdData(rdData), .irq(irq),
    .phase_a_high_drive(drv[0]), .phase_b_high_drive(drv[1]),
    .phase_c_high_drive(drv[2]), .phase_a_low_drive(drv[3]),
    .phase_b_low_drive(drv[4]), .phase_c_low_drive(drv[5]),
    .period_sync_pin_in(syncIn), .period_sync_pin_out(syncOut),
    .period_sync_pin_oe(syncOe), .shutdown_trip_input_n(tripN)
  );

  pwm_far_side far_u (
    .clk(clk), .pinOe(syncOe), .pinOut(syncOut), .pinLvl(syncIn), .tripLvlN(tripN)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // expected {low, high} of a phase for a saturating duty, 2'b00 when in range
  function automatic logic [1:0] fullPair(input logic [15:0] d, input logic [15:0] p);
    if ($signed(d) <= 0) return 2'b10;
    if ($signed({d[15], d}) > $signed({1'b0, p})) return 2'b01;
    return 2'b00;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    #1 d = rdData;
  endtask

  task automatic tally_and_finish();
    if (failures == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    wrEn = 1'b0;
    rdEn = 1'b0;
    addr = 8'h00;
    wrData = 16'h0000;
    seed = 32'h3197c9f5;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rd(pwm_pkg::OFS_PERIOD, rv);
    `CHK(rv, pwm_pkg::PERIOD_RST)
    rd(pwm_pkg::OFS_DEAD, rv);
    `CHK(rv, pwm_pkg::DEAD_RST)
    rd(pwm_pkg::OFS_OUTEN, rv);
    `CHK(rv, pwm_pkg::OUTEN_RST)
    rd(8'h2C, rv);
    `CHK(rv, pwm_pkg::RD_UNMAPPED)
    seed = lfsr(seed);
    wr(pwm_pkg::OFS_PERIOD, seed[15:0]);
    rd(pwm_pkg::OFS_PERIOD, rv);
    `CHK(rv, seed[15:0])
    // full on, full off and a mid duty
    seed = lfsr(seed);
    dutyA = {1'b0, seed[14:0]} | 16'h0010;
    dutyB = {1'b1, seed[14:0]};
    wr(pwm_pkg::OFS_PERIOD, 16'h0008);
    wr(pwm_pkg::OFS_DUTY_A, dutyA);
    wr(pwm_pkg::OFS_DUTY_B, dutyB);
    wr(pwm_pkg::OFS_DUTY_C, 16'h0004);
    wr(pwm_pkg::OFS_IRQEN, 16'h0001);
    wr(pwm_pkg::OFS_CTRL, 16'h0001);
    repeat (64) @(posedge clk);
    pulses = 0;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      #1;
      `CHK({drv[3], drv[0]}, fullPair(dutyA, 16'h0008))
      `CHK({drv[4], drv[1]}, fullPair(dutyB, 16'h0008))
      `CHK(drv[5] & drv[2], 1'b0)
      pulses += int'(syncOut);
    end
    `CHK(pulses, 1)
    wr(pwm_pkg::OFS_CTRL, 16'h0009);
    repeat (40) @(posedge clk);
    #1;
    `CHK({drv[3], drv[0]}, 2'b10)
    wr(pwm_pkg::OFS_CTRL, 16'h0001);
    repeat (40) @(posedge clk);
    // double update, then crossover with one enable off
    wr(pwm_pkg::OFS_DUTY_C, 16'h7FFF);
    wr(pwm_pkg::OFS_CTRL, 16'h0003);
    repeat (40) @(posedge clk);
    #1;
    `CHK({drv[5], drv[2]}, fullPair(16'h7FFF, 16'h0008))
    wr(pwm_pkg::OFS_OUTEN, 16'h023E);
    repeat (8) @(posedge clk);
    #1;
    `CHK({drv[4], drv[1]}, 2'b01)
    `CHK(drv[0], 1'b0)
    wr(pwm_pkg::OFS_OUTEN, pwm_pkg::OUTEN_RST);
    // reluctance: low sides forced on, then high sides forced on
    wr(pwm_pkg::OFS_CTRL, 16'h0021);
    repeat (8) @(posedge clk);
    #1;
    `CHK(drv[5:3], 3'b111)
    wr(pwm_pkg::OFS_CTRL, 16'h0031);
    repeat (8) @(posedge clk);
    #1;
    `CHK(drv[2:0], 3'b111)
    // chopping on high sides: phase A high follows the divider
    wr(pwm_pkg::OFS_CTRL, 16'h0041);
    repeat (8) @(posedge clk);
    pulses = 0;
    for (int i = 0; i < 4 * (int'(pwm_pkg::GATE_RST) + 1); i++) begin
      @(posedge clk);
      #1;
      pulses += int'(drv[0]);
    end
    `CHK(pulses, 2 * (int'(pwm_pkg::GATE_RST) + 1))
    wr(pwm_pkg::OFS_CTRL, 16'h0001);
    repeat (8) @(posedge clk);
    // trip forces all off at once, between edges, and stays latched
    #1;
    far_u.setTrip(1'b0);
    #1;
    `CHK(drv, 6'h00)
    repeat (4) @(posedge clk);
    rd(pwm_pkg::OFS_STATUS, rv);
    `CHK(rv[0], 1'b1)
    `CHK(irq, 1'b1)
    far_u.setTrip(1'b1);
    repeat (6) @(posedge clk);
    #1;
    `CHK(drv, 6'h00)
    wr(pwm_pkg::OFS_CLEAR, 16'h0001);
    rd(pwm_pkg::OFS_STATUS, rv);
    `CHK(rv[0], 1'b0)
    `CHK(irq, 1'b0)
    // external sync owns the pin
    wr(pwm_pkg::OFS_CTRL, 16'h0005);
    wr(pwm_pkg::OFS_CLEAR, 16'h0007);
    @(posedge clk);
    #1;
    `CHK(syncOe, 1'b0)
    far_u.pulse();
    repeat (4) @(posedge clk);
    rd(pwm_pkg::OFS_STATUS, rv);
    `CHK(rv[2], 1'b1)
    tally_and_finish();
  end
endmodule
